/* File: cfi_port_mapping_subchannel.sv */
// top of the serial port mapping block: frame counters, line mapping, subchannel lanes.
// assumes the reference clock and frame sync arrive as pins, slower than sys_clk by 4x or more,
// and that memory supplies slot data and bandwidth codes for the slot numbers shown.
`default_nettype none

module cfi_port_mapping_subchannel
  import cfi_map_pkg::*;
(
  input  wire logic        sys_clk,            // 250 MHz system clock
  input  wire logic        rstn,               // synchronous reset, active low
  input  wire logic        serial_ref_clock,   // reference clock pin
  input  wire logic        serial_frame_sync,  // frame sync pin
  input  wire logic [1:0]  cfi_mode,           // interface mode 0..3
  input  wire logic        rx_line_select_lo,  // port 0 input choice
  input  wire logic        rx_line_select_hi,  // port 1 input choice
  input  wire logic [7:0]  port_subslot_reg,   // subchannel codes, pair n at bits 2n+1..2n
  input  wire logic [7:0]  serial_mode_ctrl_b, // shape, clock option, edges, frame bits 9..8
  input  wire logic [7:0]  frame_bits_low,     // frame bit count bits 7..0 (bits minus one)
  input  wire logic [6:0]  slot_adjust_reg,    // marked slot number plus two
  input  wire logic [2:0]  down_shift_field,   // bit shift code
  input  wire logic [3:0]  up_shift_field,     // upstream advance in bits
  input  wire logic        output_driver_sel,  // 1 open drain, 0 tristate
  input  wire logic [63:0] tx_data,            // per-port downstream byte, port p at 8p
  input  wire logic [15:0] tx_bw,              // per-port downstream bandwidth code
  input  wire logic [15:0] rx_bw,              // per-port upstream bandwidth code
  input  wire logic [3:0]  down_line_in,       // down line pins, read in mode 3
  input  wire logic [3:0]  up_line_in,         // up line pins
  output logic [3:0]       down_line_out,      // down line drive level
  output logic [3:0]       down_line_oe,       // down line drive enable
  output logic [3:0]       up_line_out,        // up line drive level, mode 3
  output logic [3:0]       up_line_oe,         // up line drive enable, mode 3
  output logic [63:0]      rx_data,            // per-port upstream byte
  output logic [7:0]       rx_valid,           // per-port pulse, rx_data updated
  output logic [6:0]       down_slot,          // downstream slot in progress
  output logic [6:0]       up_slot,            // upstream slot in progress
  output logic             frame_start,        // pulse at downstream bit 0 of frame
  output logic [2:0]       framing_shape_sel,  // framing shape field
  output logic             out_clock_option,   // output clock option field
  output logic [1:0]       frame_bits_high     // frame bit count bits 9..8
);
  typedef struct packed {
    logic       ref_s1;     // reference clock synchroniser
    logic       ref_s2;
    logic       ref_d;      // previous synchronised level
    logic       fs_s1;      // frame sync synchroniser
    logic       fs_s2;
    logic       fs_d;       // frame sync at previous rising edge
    logic [3:0] up_s1;      // up line synchronisers
    logic [3:0] up_s2;
    logic [3:0] dn_s1;      // down line synchronisers
    logic [3:0] dn_s2;
    logic [9:0] down_cnt;   // downstream bit in frame
    logic [1:0] mode;       // frame-aligned copies of selection settings
    logic       sel_lo;
    logic       sel_hi;
    logic [7:0] sc;
    logic [6:0] down_slot;
    logic [6:0] up_slot;
    logic       frame_start;
    logic [2:0] shape;
    logic       oclk;
    logic [1:0] fbits_hi;
  } top_t;

  top_t cur;   // registered state
  top_t nxt;   // next state

  logic [9:0]  last_bit;   // frame length minus one
  logic [11:0] nbits;      // frame length
  logic [11:0] mark_pos;   // counter value at the marked bit
  logic [11:0] up_sum;     // downstream plus upstream advance
  logic [9:0]  up_cnt;     // upstream bit in frame
  logic [9:0]  cnt_plus;   // downstream counter after one bit
  logic        ref_rise;   // reference clock rising edge seen
  logic        ref_fall;   // reference clock falling edge seen
  logic        tx_launch;  // launch edge per transmit edge select
  logic        rx_sample;  // sample edge per receive edge select
  logic [2:0]  tx_bit;     // bit number being launched
  logic [2:0]  rx_bit;     // bit number being sampled
  logic [7:0]  lane_oe;    // per-port drive enable
  logic [7:0]  lane_out;   // per-port drive level
  logic [7:0]  lane_pin;   // per-port receive pin

  assign last_bit  = {serial_mode_ctrl_b[FBITS_LSB +: 2], frame_bits_low};   // R13
  assign nbits     = {2'h0, last_bit} + 12'h001;
  // slot adjust counts bytes, shift code counts bits; code 000 lands on bit 1 of slot before
  assign mark_pos  = {2'h0, slot_adjust_reg, 3'h0} + {9'h000, down_shift_field} + nbits - MARK_OFFSET; // R14
  assign up_sum    = {2'h0, cur.down_cnt} + {8'h00, up_shift_field};
  // upstream runs ahead by at most 15 bits; wrap keeps slot numbers modulo the frame
  assign up_cnt    = (up_sum >= nbits) ? 10'(up_sum - nbits) : up_sum[9:0];
  assign cnt_plus  = (cur.down_cnt >= last_bit) ? CNT_RESET : cur.down_cnt + 10'h001; // R14
  assign ref_rise  = cur.ref_s2 & ~cur.ref_d;
  assign ref_fall  = ~cur.ref_s2 & cur.ref_d;
  assign tx_launch = serial_mode_ctrl_b[TXEDGE_BIT] ? ref_fall : ref_rise;   // R16
  assign rx_sample = serial_mode_ctrl_b[RXEDGE_BIT] ? ref_rise : ref_fall;
  assign tx_bit    = ~nxt.down_cnt[2:0];
  assign rx_bit    = ~up_cnt[2:0];

  // counters, synchronisers and frame-aligned settings
  always_comb begin
    nxt        = cur;
    nxt.ref_s1 = serial_ref_clock;
    nxt.ref_s2 = cur.ref_s1;
    nxt.ref_d  = cur.ref_s2;
    nxt.fs_s1  = serial_frame_sync;
    nxt.fs_s2  = cur.fs_s1;
    nxt.up_s1  = up_line_in;
    nxt.up_s2  = cur.up_s1;
    nxt.dn_s1  = down_line_in;
    nxt.dn_s2  = cur.dn_s1;
    nxt.frame_start = 1'b0;
    nxt.shape    = serial_mode_ctrl_b[SHAPE_LSB +: 3];   // R13
    nxt.oclk     = serial_mode_ctrl_b[OCLK_BIT];         // R13
    nxt.fbits_hi = serial_mode_ctrl_b[FBITS_LSB +: 2];   // R13
    if (ref_rise) begin
      nxt.fs_d = cur.fs_s2;
      if (cur.fs_s2 && !cur.fs_d) begin
        // sync rising edge: reload at the marked bit, modulo frame length
        nxt.down_cnt = (mark_pos >= nbits) ? 10'(mark_pos - nbits) : mark_pos[9:0]; // R14
      end else begin
        nxt.down_cnt = cnt_plus;
      end
      if (nxt.down_cnt == CNT_RESET) begin
        // new settings only at a downstream frame boundary so no downstream slot is split
        nxt.mode        = cfi_mode;           // R18
        nxt.sel_lo      = rx_line_select_lo;  // R18
        nxt.sel_hi      = rx_line_select_hi;  // R18
        nxt.sc          = port_subslot_reg;   // R18
        nxt.frame_start = 1'b1;
      end
    end
    nxt.down_slot = nxt.down_cnt[9:3];
    nxt.up_slot   = up_cnt[9:3];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // receive pin per logical port; outside modes 1 and 2 the select bits are ignored
  always_comb begin
    lane_pin = 8'hFF;
    case (cur.mode)
      MODE_QUAD: begin
        lane_pin[3:0] = cur.up_s2;
      end
      MODE_DUAL: begin
        lane_pin[0] = cur.sel_lo ? cur.up_s2[2] : cur.up_s2[0];   // R02 R04
        lane_pin[1] = cur.sel_hi ? cur.up_s2[3] : cur.up_s2[1];   // R04
      end
      MODE_SINGLE: begin
        lane_pin[0] = cur.sel_lo ? cur.up_s2[2] : cur.up_s2[0];   // R05
      end
      default: begin
        lane_pin = {cur.up_s2, cur.dn_s2};                        // R06
      end
    endcase
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_lane
      cfi_lane u_lane (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        // lanes see the settings that stand after this edge, so the boundary bit already uses new ones
        .enable      (lane_enable(nxt.mode, p)),         // R06
        .driver_open (output_driver_sel),
        .sc          (lane_code(nxt.mode, p, nxt.sc)),   // R08 R09 R18
        .tx_bw       (tx_bw[2*p +: 2]),                  // R10
        .tx_byte     (tx_data[8*p +: 8]),
        .tx_launch   (tx_launch),
        .tx_bit      (tx_bit),
        .rx_bw       (rx_bw[2*p +: 2]),
        .rx_sample   (rx_sample),
        .rx_bit      (rx_bit),
        .rx_pin      (lane_pin[p]),
        .pin_out     (lane_out[p]),
        .pin_oe      (lane_oe[p]),
        .rx_byte     (rx_data[8*p +: 8]),
        .rx_done     (rx_valid[p])
      );
    end
  endgenerate

  // each port sits on a fixed line: ports 0..3 on down lines, 4..7 on up lines
  assign down_line_out     = lane_out[3:0];   // R01
  assign down_line_oe      = lane_oe[3:0];    // R01
  assign up_line_out       = lane_out[7:4];
  assign up_line_oe        = lane_oe[7:4];
  assign down_slot         = cur.down_slot;
  assign up_slot           = cur.up_slot;
  assign frame_start       = cur.frame_start;
  assign framing_shape_sel = cur.shape;
  assign out_clock_option  = cur.oclk;
  assign frame_bits_high   = cur.fbits_hi;

  a_count_wraps: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    (ref_rise && !(cur.fs_s2 && !cur.fs_d) && cur.down_cnt == last_bit) |=> cur.down_cnt == 10'h000)
    else $error("bit counter did not wrap at frame end");
  a_sync_mark: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    (ref_rise && cur.fs_s2 && !cur.fs_d && down_shift_field == 3'h0 && slot_adjust_reg == 7'h02
     && $stable(last_bit)) |=> cur.down_cnt == 10'(last_bit - 10'h001))
    else $error("sync did not mark bit 1 of prior slot");
  a_settings_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R18
    !(ref_rise && nxt.down_cnt == 10'h000) |=> $stable(cur.sc) && $stable(cur.mode))
    else $error("selection changed mid frame");
  a_dual_lines_off: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    (tx_launch && nxt.mode == MODE_DUAL) |=> (down_line_oe[3:2] == 2'h0 && up_line_oe == 4'h0))
    else $error("unused line driven in mode 1");
  a_single_line: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
    (tx_launch && nxt.mode == MODE_SINGLE) |=> (down_line_oe[3:1] == 3'h0 && up_line_oe == 4'h0))
    else $error("extra line driven in mode 2");
  a_dual_rx_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R04
    (cur.mode == MODE_DUAL && cur.sel_hi) |-> lane_pin[1] == cur.up_s2[3])
    else $error("port 1 not fed from line 3");
endmodule // cfi_port_mapping_subchannel

`default_nettype wire

/* File: cfi_map_common.sv */
// constants and shared helpers for the serial port mapping block, plus the per-port lane.
// assumes a single sys_clk domain; pins are synchronised by the top before reaching a lane.
// Behaviour
// R01: each port transmits on its own fixed line
// R02: receive line choice only in modes 1, 2
// R03: software keeps select bits zero in modes 0, 3
// R04: mode 1 selects line 0/2 and 1/3
// R05: mode 2 picks line 0 or 2
// R06: per-mode line usage, unused lines released
// R07: subchannel code picks exchanged bit positions
// R08: field pairs map ports n and n+4
// R09: mode 1/2 ports reuse port 0/1 settings
// R10: bandwidth from memory, position from port field
// R11: unused slot bits inactive, released when tristate
// R12: software uses code 00 for D channel slots
// R13: mode control b field placement
// R14: shift code 000 marks bit 1, prior slot
// R15: software handles upstream shifts beyond 15 bits
// R16: transmit edge select chooses rising or falling
// R17: tristate drives push-pull, releases idle bits
// R18: selection changes apply at frame boundary
`default_nettype none

package cfi_map_pkg;
  localparam int          NUM_PORTS    = 8;      // logical ports in bidirectional mode
  localparam int          NUM_LINES    = 4;      // physical lines per direction
  localparam logic [1:0]  MODE_QUAD    = 2'h0;   // four in/out pairs
  localparam logic [1:0]  MODE_DUAL    = 2'h1;   // two ports, selectable inputs
  localparam logic [1:0]  MODE_SINGLE  = 2'h2;   // one port
  localparam logic [1:0]  MODE_BIDIR   = 2'h3;   // eight bidirectional ports
  localparam logic [1:0]  BW_NONE      = 2'h0;   // unassigned slot
  localparam logic [1:0]  BW_64K       = 2'h1;   // full byte
  localparam logic [1:0]  BW_32K       = 2'h2;   // nibble
  localparam logic [1:0]  BW_16K       = 2'h3;   // bit pair
  localparam int          SHAPE_LSB    = 5;      // framing shape select, bits 7..5
  localparam int          OCLK_BIT     = 4;      // output clock option
  localparam int          TXEDGE_BIT   = 3;      // transmit edge select
  localparam int          RXEDGE_BIT   = 2;      // receive edge select
  localparam int          FBITS_LSB    = 0;      // frame bit count bits 9..8
  localparam logic [11:0] MARK_OFFSET  = 12'h012; // slot adjust +2 and bit 1 of prior slot
  localparam logic [9:0]  CNT_RESET    = 10'h000; // bit counter after reset

  // port p drives its line only where the mode gives it one
  function automatic logic lane_enable(input logic [1:0] mode, input int p);
    case (mode)
      MODE_QUAD:   lane_enable = (p < 4);
      MODE_DUAL:   lane_enable = (p < 2);
      MODE_SINGLE: lane_enable = (p == 0);
      default:     lane_enable = 1'b1;
    endcase
  endfunction

  // which subchannel field pair port p follows
  function automatic logic [1:0] lane_code(input logic [1:0] mode, input int p, input logic [7:0] sc);
    case (mode)
      MODE_DUAL:   lane_code = sc[2*(p%2) +: 2];
      MODE_SINGLE: lane_code = sc[1:0];
      default:     lane_code = sc[2*(p%4) +: 2];
    endcase
  endfunction
endpackage

// one logical port: bit selection, driver style, receive shifting
module cfi_lane
  import cfi_map_pkg::*;
(
  input  wire logic       sys_clk,     // system clock
  input  wire logic       rstn,        // synchronous reset, active low
  input  wire logic       enable,      // port owns a physical line in this mode
  input  wire logic       driver_open, // 1 open drain, 0 tristate
  input  wire logic [1:0] sc,          // subchannel code for this port
  input  wire logic [1:0] tx_bw,       // bandwidth of current downstream slot
  input  wire logic [7:0] tx_byte,     // data for current downstream slot
  input  wire logic       tx_launch,   // launch edge pulse
  input  wire logic [2:0] tx_bit,      // bit position being launched
  input  wire logic [1:0] rx_bw,       // bandwidth of current upstream slot
  input  wire logic       rx_sample,   // sample edge pulse
  input  wire logic [2:0] rx_bit,      // bit position being sampled
  input  wire logic       rx_pin,      // synchronised receive pin
  output logic            pin_out,     // line level when driven
  output logic            pin_oe,      // line drive enable
  output logic [7:0]      rx_byte,     // received slot, idle bits read 1
  output logic            rx_done      // one-cycle pulse, rx_byte updated
);
  typedef struct packed {
    logic       pin_out;
    logic       pin_oe;
    logic [7:0] shift;
    logic [7:0] rx_byte;
    logic       rx_done;
  } lane_t;

  lane_t cur;   // registered state
  lane_t nxt;   // next state

  // bit belongs to the subchannel picked by code and bandwidth
  function automatic logic bit_used(input logic [1:0] bw, input logic [1:0] code, input logic [2:0] b);
    case (bw)
      BW_64K:  bit_used = 1'b1;                      // R07
      BW_32K:  bit_used = (b[2] == ~code[0]);        // R07
      BW_16K:  bit_used = (b[2:1] == ~code);         // R07
      default: bit_used = 1'b0;                      // R11
    endcase
  endfunction

  logic tx_act;   // launched bit is live
  assign tx_act = enable & bit_used(tx_bw, sc, tx_bit);   // R10

  // launch and capture
  always_comb begin
    nxt         = cur;
    nxt.rx_done = 1'b0;
    if (tx_launch) begin
      nxt.pin_out = tx_byte[tx_bit];                        // R16
      // open drain only pulls low; tristate drives both levels
      nxt.pin_oe  = tx_act & (~driver_open | ~tx_byte[tx_bit]); // R17
    end
    if (rx_sample) begin
      nxt.shift[rx_bit] = bit_used(rx_bw, sc, rx_bit) ? rx_pin : 1'b1; // R07
      if (rx_bit == 3'h0) begin
        nxt.rx_byte    = nxt.shift;
        nxt.rx_done    = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur <= '{pin_out: 1'b1, pin_oe: 1'b0, shift: 8'hFF, rx_byte: 8'hFF, rx_done: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign pin_out = cur.pin_out;
  assign pin_oe  = cur.pin_oe;
  assign rx_byte = cur.rx_byte;
  assign rx_done = cur.rx_done;

  a_idle_release: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    (tx_launch && !tx_act) |=> !pin_oe) else $error("idle bit still driven");
  a_open_drain_hi: assert property (@(posedge sys_clk) disable iff (!rstn) // R17
    (tx_launch && driver_open && tx_byte[tx_bit]) |=> !pin_oe) else $error("open drain drove a one");
  a_tristate_drive: assert property (@(posedge sys_clk) disable iff (!rstn) // R17
    (tx_launch && tx_act && !driver_open) |=> (pin_oe && pin_out == $past(tx_byte[tx_bit])))
    else $error("tristate bit not driven");
  a_sub_nibble: assert property (@(posedge sys_clk) disable iff (!rstn) // R07
    (tx_launch && enable && tx_bw == BW_32K && sc[0] && tx_bit[2] && !driver_open) |=> !pin_oe)
    else $error("upper nibble driven for low nibble code");
endmodule // cfi_lane

`default_nettype wire

/* File: cfi_line_model.sv */
// line transceiver model: serial reference clock, frame sync and line data.
// assumes a 32-bit frame; the bench resolves shared lines against the design drive.
`default_nettype none

module cfi_line_model (
  input  wire logic       mode3,    // feed down lines as inputs of ports 0..3
  input  wire logic [7:0] pat,      // data pattern seed
  input  wire logic [4:0] off,      // design down count at sync
  input  wire logic [3:0] us,       // upstream advance in bits
  input  wire logic       late,     // design samples on rises: lines change on falls
  output logic            ref_clk,  // serial reference clock, free running
  output logic            fsync,    // frame sync
  output logic [3:0]      up_drv,   // up line levels
  output logic [3:0]      dn_drv,   // down line levels, pulled high unless mode 3
  output logic [4:0]      down_idx, // down bit index in frame
  output logic [4:0]      up_idx    // up bit index in frame
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] r = 5'h1F; // raw bit count, wraps with the frame

  // reference clock runs free, 160 ns period
  initial ref_clk = 1'b0;
  always #80 ref_clk = ~ref_clk;

  // sync changes on falls so it is stable across the rise that starts the frame
  initial fsync = 1'b0;
  always @(negedge ref_clk) fsync <= (r == 5'h1F);

  // one bit per reference period
  always @(posedge ref_clk) r <= r + 5'h01;

  assign down_idx = r + off;
  assign up_idx   = r + off + {1'b0, us};

  // line bit: slot byte from pattern, MSB first
  function automatic logic pbit(input int src, input logic [4:0] idx);
    logic [7:0] b;
    b = pat ^ {src[2:0], 3'h0, idx[4:3]};
    return b[3'h7 - idx[2:0]];
  endfunction

  // lines change on the edge the design does not sample on, so each bit is settled when taken
  logic [4:0] held = 5'h00;                 // upstream index latched at falls
  always @(negedge ref_clk) held <= up_idx;
  wire  [4:0] shown = late ? held : up_idx; // upstream index on the lines

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      up_drv[l] = pbit(l, shown);
      dn_drv[l] = mode3 ? pbit(l + 4, shown) : 1'b1;
    end
  end
endmodule // cfi_line_model

`default_nettype wire

/* File: cfi_port_mapping_subchannel_tb.sv */
// bench for the serial port mapping block: random settings per pass, line model on the far side.
// assumes a 32-bit frame of four slots; mode 3 always samples on the falling reference edge.
`default_nettype none

module cfi_port_mapping_subchannel_tb
  import cfi_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;      // 250 MHz
  logic        rstn = 1'b0;         // synchronous reset, low
  logic [1:0]  mode = 2'h0;         // interface mode
  logic        sel_lo = 1'b0;       // port 0 input choice
  logic        sel_hi = 1'b0;       // port 1 input choice
  logic [7:0]  sc = 8'h00;          // subchannel codes
  logic [7:0]  ctrl_b = 8'h00;      // mode control b
  logic [1:0]  adj = 2'h2;          // slot adjust, kept in the legal range
  logic [2:0]  dsh = 3'h2;          // down shift code
  logic [3:0]  us = 4'h0;           // up shift
  logic        ods = 1'b0;          // 1 open drain
  logic [7:0]  pat = 8'h00;         // line pattern
  logic [63:0] tx_data = 64'h0;     // downstream bytes
  logic [15:0] tx_bw = 16'h0000;    // downstream bandwidth codes
  logic [15:0] rx_bw = 16'h5555;    // upstream bandwidth codes
  logic        armed = 1'b0;        // expectations are being noted
  int          err_total = 0;       // mismatches
  int          samples_checked = 0; // comparisons
  int          cycles = 0;          // timeout counter
  int          fs_seen = 0;         // frame starts while armed
  logic [10:0] rx_q[$];             // {port, byte}
  logic [31:0] tx_q[$];             // {slots, line drive} per bit
  wire         serial_ref_clock, serial_frame_sync;
  wire  [3:0]  down_line_in, up_line_in, down_line_out, down_line_oe, up_line_out, up_line_oe;
  wire  [3:0]  up_drv, dn_drv;
  wire  [4:0]  down_idx, up_idx;
  wire  [63:0] rx_data;
  wire  [7:0]  rx_valid;
  wire  [2:0]  shape;
  wire         oclk;
  wire  [1:0]  fbh;
  wire  [6:0]  dslot, uslot;        // slot numbers in progress
  wire         fstart;              // frame start pulse
  wire  [4:0]  off = {adj, 3'h0} + {2'h0, dsh} - 5'h12;
  wire  [15:0] tx_seen = {down_line_oe, down_line_out & down_line_oe, up_line_oe, up_line_out & up_line_oe};

  // released lines read the model's level, or the pull-up
  assign down_line_in = (down_line_oe & down_line_out) | (~down_line_oe & dn_drv);
  assign up_line_in   = (up_line_oe & up_line_out) | (~up_line_oe & up_drv);

  always #2 sys_clk = ~sys_clk;

  cfi_port_mapping_subchannel u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .serial_ref_clock(serial_ref_clock),
    .serial_frame_sync(serial_frame_sync), .cfi_mode(mode), .rx_line_select_lo(sel_lo),
    .rx_line_select_hi(sel_hi), .port_subslot_reg(sc), .serial_mode_ctrl_b(ctrl_b),
    .frame_bits_low(8'h1F), .slot_adjust_reg({5'h00, adj}), .down_shift_field(dsh),
    .up_shift_field(us), .output_driver_sel(ods), .tx_data(tx_data), .tx_bw(tx_bw), .rx_bw(rx_bw),
    .down_line_in(down_line_in), .up_line_in(up_line_in), .down_line_out(down_line_out),
    .down_line_oe(down_line_oe), .up_line_out(up_line_out), .up_line_oe(up_line_oe),
    .rx_data(rx_data), .rx_valid(rx_valid), .down_slot(dslot), .up_slot(uslot), .frame_start(fstart),
    .framing_shape_sel(shape), .out_clock_option(oclk), .frame_bits_high(fbh));

  cfi_line_model u_line (
    .mode3(mode == MODE_BIDIR), .pat(pat), .off(off), .us(us), .late(ctrl_b[2]), .ref_clk(serial_ref_clock),
    .fsync(serial_frame_sync), .up_drv(up_drv), .dn_drv(dn_drv), .down_idx(down_idx), .up_idx(up_idx));

  // port owns a line in the current mode
  function automatic logic owns(input int p);
    case (mode)
      MODE_QUAD:   return p < 4;
      MODE_DUAL:   return p < 2;
      MODE_SINGLE: return p == 0;
      default:     return 1'b1;
    endcase
  endfunction

  // subchannel field that port p follows
  function automatic logic [1:0] code_of(input int p);
    case (mode)
      MODE_DUAL:   return sc[2*(p%2) +: 2];
      MODE_SINGLE: return sc[1:0];
      default:     return sc[2*(p%4) +: 2];
    endcase
  endfunction

  // pattern source feeding port p
  function automatic int src_of(input int p);
    case (mode)
      MODE_DUAL:   return p + 2 * (p == 0 ? sel_lo : sel_hi);
      MODE_SINGLE: return 2 * sel_lo;
      MODE_BIDIR:  return p < 4 ? p + 4 : p - 4;
      default:     return p;
    endcase
  endfunction

  // exchanged bits for a bandwidth and code
  function automatic logic [7:0] mask_of(input logic [1:0] bw, input logic [1:0] c);
    case (bw)
      2'h1:    return 8'hFF;
      2'h2:    return c[0] ? 8'h0F : 8'hF0;
      2'h3:    return 8'hC0 >> (2 * c);
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rx_expect(input int p, input logic [1:0] slot);
    int         s;
    logic [7:0] m;
    s = src_of(p);
    m = mask_of(rx_bw[2*p +: 2], code_of(p));
    return (pat ^ {s[2:0], 3'h0, slot}) | ~m; // idle bits read 1
  endfunction

  // drive of all eight lines for one down bit
  function automatic logic [15:0] tx_expect(input logic [4:0] idx);
    logic [15:0] e;
    logic [7:0]  m;
    logic [2:0]  j;
    logic        d;
    logic        oe;
    e = 16'h0000;
    j = 3'h7 - idx[2:0];
    for (int p = 0; p < 8; p++) begin
      m = mask_of(tx_bw[2*p +: 2], code_of(p));
      d = tx_data[8*p + j];
      oe = owns(p) & m[j] & (ods ? ~d : 1'b1);
      e[p < 4 ? 12 + p : p] = oe;
      e[p < 4 ? 8 + p : p - 4] = oe & ~ods & d;
    end
    return e;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // note the line drive just after each rise; a falling-edge launch still shows the prior bit
  always @(posedge serial_ref_clock) begin
    #1;
    if (armed) tx_q.push_back({7'h00, down_idx[4:3], 5'h00, up_idx[4:3],
                               tx_expect(ctrl_b[3] ? down_idx - 5'h01 : down_idx)});
  end

  // compare a quarter period after each rise, well clear of both launch edges
  always @(posedge serial_ref_clock) begin : tx_cmp
    logic [31:0] e; // oldest note
    #40;
    if (tx_q.size() > 0) begin
      e = tx_q.pop_front();
      chk(tx_seen, e[15:0]);
      chk({2'h0, dslot, uslot}, e[31:16]);
    end
  end

  // bit 0 of an upstream slot is on the lines: note each owned port's byte
  always @(negedge serial_ref_clock) begin
    if (armed && up_idx[2:0] == 3'h7)
      for (int p = 0; p < 8; p++)
        if (owns(p)) rx_q.push_back({p[2:0], rx_expect(p, up_idx[4:3])});
  end

  // each receive pulse takes the oldest note
  always @(negedge sys_clk) begin
    if (armed)
      for (int p = 0; p < 8; p++)
        if (rx_valid[p] === 1'b1 && owns(p))
          chk({5'h00, p[2:0], rx_data[8*p +: 8]}, rx_q.size() > 0 ? rx_q.pop_front() : 'x);
  end

  // frame start pulses while armed; each window spans exactly two frames
  always @(negedge sys_clk) begin
    if (armed && fstart === 1'b1) fs_seen++;
  end

  // hang guard, about 28% above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end

  initial begin
    void'($urandom(32'hC9D921A1));
    repeat (19) @(negedge sys_clk);
    chk({down_line_oe, up_line_oe, rx_valid}, 16'h0000);
    @(negedge sys_clk);
    rstn = 1'b1;
    // each pass: random settings, let them latch, then check two frames
    for (int t = 0; t < 8; t++) begin
      @(negedge sys_clk);
      mode = t[1:0];
      sel_lo = (mode == MODE_DUAL || mode == MODE_SINGLE) ? 1'($urandom) : 1'b0;
      sel_hi = (mode == MODE_DUAL) ? 1'($urandom) : 1'b0;
      // last pass keeps code 00 on every port, as for switched D channel slots
      sc = (t == 7) ? 8'h00 : 8'($urandom);
      // receive edge is random except in mode 3, which samples on falls only
      ctrl_b = {4'($urandom), 1'($urandom), (mode == MODE_BIDIR) ? 1'b0 : 1'($urandom), 2'h0};
      // pass 6 marks bit 1 of the slot before slot 0
      adj = (t == 6) ? 2'h2 : 2'($urandom);
      dsh = (t == 6) ? 3'h0 : 3'($urandom);
      us = 4'($urandom);
      ods = 1'($urandom);
      pat = 8'($urandom);
      tx_data = {$urandom, $urandom};
      for (int p = 0; p < 8; p++) begin
        rx_bw[2*p +: 2] = 2'($urandom_range(3, 1));
        tx_bw[2*p +: 2] = (mode == MODE_BIDIR) ? 2'h0 : 2'($urandom);
      end
      repeat (80) @(posedge serial_ref_clock);
      #20 armed = 1'b1;
      repeat (64) @(posedge serial_ref_clock);
      #20 armed = 1'b0;
      chk({8'h00, shape, oclk, fbh}, {8'h00, ctrl_b[7:4], ctrl_b[1:0]});
      chk(16'(fs_seen), 16'h0002);
      fs_seen = 0;
      repeat (2) @(posedge serial_ref_clock);
      chk(16'(rx_q.size() + tx_q.size()), 16'h0000);
    end
    results();
  end
endmodule // cfi_port_mapping_subchannel_tb

`default_nettype wire
